/* rtl/otss_pkg.sv */
package otss_pkg;

  // ***************************************************
  // register map
  // ***************************************************
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_COUPLED  = 4'h1;
  localparam logic [3:0] ADDR_COM_OFF  = 4'h2;
  localparam logic [3:0] ADDR_MAX_OFF  = 4'h3;
  localparam logic [3:0] ADDR_STATUS   = 4'h4;
  localparam logic [3:0] ADDR_CMD      = 4'h5;
  localparam logic [3:0] ADDR_ON_DLY0  = 4'h8;
  localparam logic [3:0] ADDR_OFF_DLY0 = 4'hc;

  localparam int CTRL_SYNC_BIT = 0;
  localparam int CMD_ON_BIT    = 0;
  localparam int CMD_OFF_BIT   = 1;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_HZ       = 100_000_000;
  localparam int TICK_US      = 1000;
  localparam int TICK_CYCLES  = CLK_HZ / 1_000_000 * TICK_US;

  // ***************************************************
  // module kinds and intrinsic offsets in ms
  // ***************************************************
  typedef enum logic [1:0] {
    MOD_KIND_A = 2'h0,
    MOD_KIND_B = 2'h1,
    MOD_KIND_C = 2'h2,
    MOD_KIND_D = 2'h3
  } otss_kind_t;

  localparam logic [7:0] OFS_A_PLAIN    = 8'd32;
  localparam logic [7:0] OFS_A_RELAY    = 8'd58;
  localparam logic [7:0] OFS_B_PLAIN    = 8'd25;
  localparam logic [7:0] OFS_B_RELAY    = 8'd51;
  localparam logic [7:0] OFS_C_PLAIN    = 8'd18;
  localparam logic [7:0] OFS_C_RELAY    = 8'd44;
  localparam logic [7:0] OFS_D_PLAIN    = 8'd32;
  localparam logic [7:0] OFS_D_RELAY    = 8'd58;
  localparam logic [7:0] OFS_D_PLAIN_CP = 8'd23;
  localparam logic [7:0] OFS_D_RELAY_CP = 8'd45;

  typedef struct packed {
    otss_kind_t kind;
    logic       relay;
    logic       cur_prio;
  } otss_mod_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } otss_bus_t;

endpackage

/* rtl/otss_chan.sv */
`timescale 1ns/1ns
module otss_chan
  import otss_pkg::*;
#(
  parameter int DW = 16
) (
  input  wire logic          clock,
  input  wire logic          reset_n,
  input  wire logic          tick,
  input  wire logic          start_on,
  input  wire logic          start_off,
  input  wire logic [7:0]    intrinsic,
  input  wire logic [DW-1:0] on_delay,
  input  wire logic [DW-1:0] off_delay,
  output logic               out_on
);

  // ***************************************************
  // per-channel sequencer
  // ***************************************************
  typedef enum logic [3:0] {
    CH_IDLE  = 4'b0001,
    CH_INTR  = 4'b0010,
    CH_RISE  = 4'b0100,
    CH_FALL  = 4'b1000
  } otss_ch_state_t;

  otss_ch_state_t      state_reg, state_next;
  logic [DW-1:0]       cnt_reg, cnt_next;
  logic                on_reg, on_next;

  wire logic           cnt_zero = (cnt_reg == '0);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    on_next    = on_reg;
    if (start_off) begin
      state_next = CH_FALL;
      cnt_next   = off_delay;
    end else if (start_on) begin
      state_next = CH_INTR;
      cnt_next   = {{(DW-8){1'b0}}, intrinsic};
    end else begin
      case (state_reg)
        CH_IDLE: ;
        CH_INTR: begin
          if (cnt_zero) begin
            state_next = CH_RISE;
            cnt_next   = on_delay;
          end else if (tick) begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        CH_RISE: begin
          if (cnt_zero) begin
            state_next = CH_IDLE;
            on_next    = 1'b1;
          end else if (tick) begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        CH_FALL: begin
          if (cnt_zero) begin
            state_next = CH_IDLE;
            on_next    = 1'b0;
          end else if (tick) begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        default: state_next = CH_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_reg <= CH_IDLE;
      cnt_reg   <= '0;
      on_reg    <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      on_reg    <= on_next;
    end
  end

  assign out_on = on_reg;

endmodule

/* rtl/otss_top.sv */
`timescale 1ns/1ns
module otss_top
  import otss_pkg::*;
#(
  parameter int NCH         = 4,
  parameter int DW          = 16,
  parameter int TICK_CYC    = TICK_CYCLES
) (
  input  wire logic                clock,
  input  wire logic                reset_n,
  input  wire logic [3:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  input  wire otss_pkg::otss_mod_t module_info [NCH],
  input  wire logic                panel_on,
  input  wire logic                panel_off,
  output logic [NCH-1:0]           out_on
);

  // ***************************************************
  // bus capture
  // ***************************************************
  otss_bus_t bus;
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic             sync_en_reg;
  logic [NCH-1:0]   coupled_reg;
  logic [DW-1:0]    com_off_reg;
  logic [DW-1:0]    on_dly_reg  [NCH];
  logic [DW-1:0]    off_dly_reg [NCH];
  logic [31:0]      rdata_reg, rdata_next;

  wire logic wr_ctrl    = bus.wr && bus.addr == ADDR_CTRL;
  wire logic wr_coupled = bus.wr && bus.addr == ADDR_COUPLED;
  wire logic wr_com     = bus.wr && bus.addr == ADDR_COM_OFF;
  wire logic wr_cmd     = bus.wr && bus.addr == ADDR_CMD;
  wire logic cmd_on     = wr_cmd && bus.wdata[CMD_ON_BIT];
  wire logic cmd_off    = wr_cmd && bus.wdata[CMD_OFF_BIT];

  // ***************************************************
  // front panel keys, asynchronous pins
  // ***************************************************
  logic [1:0] key_s1_reg, key_s2_reg, key_s3_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      key_s1_reg <= 2'h0;
      key_s2_reg <= 2'h0;
      key_s3_reg <= 2'h0;
    end else begin
      key_s1_reg <= {panel_off, panel_on};
      key_s2_reg <= key_s1_reg;
      key_s3_reg <= key_s2_reg;
    end
  end

  wire logic key_on  = key_s2_reg[0] && !key_s3_reg[0];
  wire logic key_off = key_s2_reg[1] && !key_s3_reg[1];

  // off wins when both arrive together, safer for the load
  wire logic ev_off = cmd_off || key_off;
  wire logic ev_on  = (cmd_on || key_on) && !ev_off;

  // ***************************************************
  // intrinsic offsets per channel
  // ***************************************************
  logic [7:0] intr [NCH];
  logic [7:0] max_intr [NCH+1];
  assign max_intr[0] = 8'h00;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_intr
      always_comb begin
        case (module_info[g].kind)
          MOD_KIND_A: intr[g] = module_info[g].relay ? OFS_A_RELAY : OFS_A_PLAIN;
          MOD_KIND_B: intr[g] = module_info[g].relay ? OFS_B_RELAY : OFS_B_PLAIN;
          MOD_KIND_C: intr[g] = module_info[g].relay ? OFS_C_RELAY : OFS_C_PLAIN;
          MOD_KIND_D: begin
            if (module_info[g].cur_prio) begin
              intr[g] = module_info[g].relay ? OFS_D_RELAY_CP : OFS_D_PLAIN_CP;
            end else begin
              intr[g] = module_info[g].relay ? OFS_D_RELAY : OFS_D_PLAIN;
            end
          end
          default: intr[g] = OFS_A_RELAY;
        endcase
      end
      assign max_intr[g+1] = (intr[g] > max_intr[g]) ? intr[g] : max_intr[g];
    end
  endgenerate

  // ***************************************************
  // ms tick divider and shared offset counter
  // ***************************************************
  logic [31:0]   div_reg;
  logic          tick_reg;
  logic [DW-1:0] shared_cnt_reg;
  logic          shared_busy_reg;

  wire logic div_end = (div_reg == 32'(TICK_CYC - 1));
  wire logic shared_done = shared_busy_reg && shared_cnt_reg == '0;
  wire logic synced = sync_en_reg;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      div_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_end ? 32'h0 : div_reg + 32'h1;
      tick_reg <= div_end;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shared_busy_reg <= 1'b0;
      shared_cnt_reg  <= '0;
    end else if (ev_off || !synced) begin
      shared_busy_reg <= 1'b0;
    end else if (ev_on) begin
      shared_busy_reg <= 1'b1;
      shared_cnt_reg  <= com_off_reg;
    end else if (shared_done) begin
      shared_busy_reg <= 1'b0;
    end else if (shared_busy_reg && tick_reg) begin
      shared_cnt_reg  <= shared_cnt_reg - 1'b1;
    end
  end

  // ***************************************************
  // channels
  // ***************************************************
  logic [NCH-1:0] ch_on;

  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      // coupled channels skip intrinsic time while sync is enabled: common offset covers it
      wire logic in_sync  = synced && coupled_reg[g];
      wire logic st_on    = in_sync ? shared_done : ev_on;
      wire logic [7:0] iv = in_sync ? 8'h00 : intr[g];
      otss_chan #(.DW(DW)) u_chan (
        .clock     (clock),
        .reset_n   (reset_n),
        .tick      (tick_reg),
        .start_on  (st_on),
        .start_off (ev_off),
        .intrinsic (iv),
        .on_delay  (on_dly_reg[g]),
        .off_delay (off_dly_reg[g]),
        .out_on    (ch_on[g])
      );
    end
  endgenerate

  // ***************************************************
  // registers
  // ***************************************************
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sync_en_reg <= 1'b0;
      coupled_reg <= '0;
      com_off_reg <= '0;
    end else begin
      if (wr_ctrl) sync_en_reg <= bus.wdata[CTRL_SYNC_BIT];
      if (wr_coupled) coupled_reg <= bus.wdata[NCH-1:0];
      if (wr_com) com_off_reg <= bus.wdata[DW-1:0];
    end
  end

  generate
    for (g = 0; g < NCH; g++) begin : g_dly
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          on_dly_reg[g]  <= '0;
          off_dly_reg[g] <= '0;
        end else begin
          if (bus.wr && bus.addr == ADDR_ON_DLY0 + 4'(g)) on_dly_reg[g] <= bus.wdata[DW-1:0];
          if (bus.wr && bus.addr == ADDR_OFF_DLY0 + 4'(g)) off_dly_reg[g] <= bus.wdata[DW-1:0];
        end
      end
    end
  endgenerate

  // ***************************************************
  // read mux
  // ***************************************************
  always_comb begin
    rdata_next = 32'h0;
    if (bus.rd) begin
      if (bus.addr == ADDR_CTRL) begin
        rdata_next[CTRL_SYNC_BIT] = sync_en_reg;
      end else if (bus.addr == ADDR_COUPLED) begin
        rdata_next[NCH-1:0] = coupled_reg;
      end else if (bus.addr == ADDR_COM_OFF) begin
        rdata_next[DW-1:0] = com_off_reg;
      end else if (bus.addr == ADDR_MAX_OFF) begin
        rdata_next[7:0] = max_intr[NCH];
      end else if (bus.addr == ADDR_STATUS) begin
        rdata_next[NCH-1:0] = ch_on;
      end
      for (int i = 0; i < NCH; i++) begin
        if (bus.addr == ADDR_ON_DLY0 + 4'(i)) rdata_next[DW-1:0] = on_dly_reg[i];
        if (bus.addr == ADDR_OFF_DLY0 + 4'(i)) rdata_next[DW-1:0] = off_dly_reg[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= 32'h0;
      out_on    <= '0;
    end else begin
      rdata_reg <= rdata_next;
      out_on    <= ch_on;
    end
  end

  assign rdata = rdata_reg;

endmodule

/* bench/otss_monitor.sv */
`timescale 1ns/1ns
module otss_monitor #(
  parameter int NCH      = 4,
  parameter int TICK_CYC = 10
) (
  input wire logic           clock,
  input wire logic           reset_n,
  input wire logic [3:0]     addr,
  input wire logic [31:0]    wdata,
  input wire logic           wr,
  input wire logic           rd,
  input wire logic [31:0]    rdata,
  input wire logic           panel_on,
  input wire logic           panel_off,
  input wire logic [NCH-1:0] out_on
);
  import otss_pkg::*;
  // ****************
  // event tracking
  // ****************
  logic           sync_reg, last_reg, pon_reg, poff_reg;
  logic [7:0]     ofs_reg;
  logic [NCH-1:0] cpl_reg;
  logic [19:0]    since_reg;
  wire cmd_wr = wr && addr == ADDR_CMD;
  wire ev_on  = (cmd_wr && wdata[CMD_ON_BIT]) || (panel_on && !pon_reg);
  wire ev_off = (cmd_wr && wdata[CMD_OFF_BIT]) || (panel_off && !poff_reg);
  // panel edges seen before the design's synchroniser: bounds stay conservative
  always_ff @(posedge clock) begin
    pon_reg <= panel_on;
    poff_reg <= panel_off;
    since_reg <= ev_on ? 20'h0 : since_reg + 20'h1;
    last_reg <= !ev_off && (ev_on || last_reg);
    if (wr && addr == ADDR_CTRL) sync_reg <= wdata[CTRL_SYNC_BIT];
    if (wr && addr == ADDR_COUPLED) cpl_reg <= wdata[NCH-1:0];
    if (wr && addr == ADDR_COM_OFF) ofs_reg <= wdata[7:0];
    if (!reset_n) begin
      last_reg <= 1'b0;
      sync_reg <= 1'b0;
      cpl_reg <= '0;
      ofs_reg <= 8'h0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence s_wr_rd(logic [3:0] a);
    wr && addr == a ##1 rd && addr == a;
  endsequence
  chk_rdata_idle: assert property (
    !rd |=> rdata == 32'h0) else $error("read data outside slot");
  chk_max_range: assert property (
    rd && addr == ADDR_MAX_OFF |=> rdata inside {[32'd18:32'd58]}) else $error("bad max");
  chk_cmd_quiet: assert property (
    rd && (addr == ADDR_CMD || addr == 4'h6) |=> rdata == 32'h0) else $error("bad read");
  chk_sync_readback: assert property (
    s_wr_rd(ADDR_CTRL) |=> rdata[0] == $past(wdata[0], 2)) else $error("bad enable");
  chk_set_readback: assert property (
    s_wr_rd(ADDR_COUPLED) |=> rdata[NCH-1:0] == $past(wdata[NCH-1:0], 2)) else $error("bad set");
  chk_ofs_readback: assert property (
    s_wr_rd(ADDR_COM_OFF) |=> rdata[7:0] == $past(wdata[7:0], 2)) else $error("bad offset");
  for (genvar k = 0; k < NCH; k++) begin : g_ch
    chk_on_delay: assert property (
      $rose(out_on[k]) |-> since_reg + TICK_CYC >=
      ((sync_reg && cpl_reg[k]) ? ofs_reg : 8'd18) * TICK_CYC) else $error("on too early");
    chk_on_latest: assert property (
      $rose(out_on[k]) |-> last_reg || $past(last_reg, 4)) else $error("on after off");
  end
endmodule
bind otss_top otss_monitor #(.NCH(NCH), .TICK_CYC(TICK_CYC)) otss_monitor_inst (
  .clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .panel_on(panel_on), .panel_off(panel_off), .out_on(out_on));

/* bench/otss_host.sv */
`timescale 1ns/1ns
module otss_host #(
  parameter int NCH = 4
) (
  input  wire logic           clock,
  input  wire logic [31:0]    rdata,
  output otss_pkg::otss_bus_t bus
);
  import otss_pkg::*;
  // ****************
  // bus cycles
  // ****************
  initial bus = '0;
  task automatic bus_op(input logic w, r, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    bus_op(1'b1, 1'b0, a, d);
    bus_op(1'b0, 1'b0, a, d);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    bus_op(1'b0, 1'b1, a, 32'h0);
    bus_op(1'b0, 1'b0, a, 32'h0);
    @(posedge clock);
    d = rdata;
  endtask
  task automatic setup(input logic sync, input logic [NCH-1:0] cpl, input int on_d[NCH],
                       input int off_d[NCH]);
    logic [31:0] mx;
    wr_reg(ADDR_CTRL, 32'(sync));
    wr_reg(ADDR_COUPLED, 32'(cpl));
    for (int k = 0; k < NCH; k++) begin
      wr_reg(4'(ADDR_ON_DLY0 + k), 32'(on_d[k]));
      wr_reg(4'(ADDR_OFF_DLY0 + k), 32'(off_d[k]));
    end
    // offset one above the slowest module, never below it
    rd_reg(ADDR_MAX_OFF, mx);
    wr_reg(ADDR_COM_OFF, mx + 32'h1);
  endtask
endmodule

/* bench/otss_top_tb.sv */
`timescale 1ns/1ns
module otss_top_tb;
  import otss_pkg::*;
  localparam int NCH = 4;
  localparam int TC  = 10;
  logic           clock = 1'b0;
  logic           reset_n = 1'b0;
  logic           panel_on = 1'b0;
  logic           panel_off = 1'b0;
  logic [31:0]    rdata, v, w;
  logic [NCH-1:0] out_on, cpl;
  logic [3:0]     rb_a[3] = '{ADDR_CTRL, ADDR_COUPLED, ADDR_COM_OFF};
  logic [31:0]    rb_m[3] = '{32'h1, 32'hf, 32'hff};
  otss_bus_t      bus;
  otss_mod_t      minfo[NCH];
  int             miscompares = 0;
  int             samples_checked = 0;
  int             cycles = 0;
  int             seed = 32'h49f181cf;
  int             mx, n, on_d[NCH], off_d[NCH], t_ev[NCH];
  otss_host #(.NCH(NCH)) otss_host_inst (.clock(clock), .rdata(rdata), .bus(bus));
  otss_top #(.NCH(NCH), .TICK_CYC(TC)) otss_top_inst (
    .clock(clock), .reset_n(reset_n), .addr(bus.addr), .wdata(bus.wdata), .wr(bus.wr),
    .rd(bus.rd), .rdata(rdata), .module_info(minfo), .panel_on(panel_on),
    .panel_off(panel_off), .out_on(out_on));
  // ****************
  // helpers
  // ****************
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run();
    end
  end
  function automatic int intr(otss_mod_t m);
    case (m.kind)
      MOD_KIND_A: return m.relay ? OFS_A_RELAY : OFS_A_PLAIN;
      MOD_KIND_B: return m.relay ? OFS_B_RELAY : OFS_B_PLAIN;
      MOD_KIND_C: return m.relay ? OFS_C_RELAY : OFS_C_PLAIN;
      default: return m.cur_prio ? (m.relay ? OFS_D_RELAY_CP : OFS_D_PLAIN_CP)
                                 : (m.relay ? OFS_D_RELAY : OFS_D_PLAIN);
    endcase
  endfunction
  function automatic int max_intr();
    int r = 0;
    for (int k = 0; k < NCH; k++) if (intr(minfo[k]) > r) r = intr(minfo[k]);
    return r;
  endfunction
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected value at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_win(input int lo, input int hi, input int g);
    samples_checked++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("unexpected time at %0t: exp %h..%h got %h", $time, lo, hi, g);
    end
  endtask
  // first cycle each output reaches lvl; -1 when it never does
  task automatic measure(input logic lvl);
    for (int k = 0; k < NCH; k++) t_ev[k] = -1;
    for (int c = 1; c < 800; c++) begin
      @(posedge clock);
      if (c == 4) begin
        panel_on <= 1'b0;
        panel_off <= 1'b0;
      end
      for (int k = 0; k < NCH; k++) if (t_ev[k] < 0 && out_on[k] === lvl) t_ev[k] = c;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    for (int k = 0; k < NCH; k++) minfo[k] = '0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < NCH; k++) minfo[k] <= otss_mod_t'(4'(i));
      otss_host_inst.rd_reg(ADDR_MAX_OFF, v);
      chk_val(32'(intr(otss_mod_t'(4'(i)))), v);
    end
    for (int k = 0; k < NCH; k++) minfo[k] <= otss_mod_t'(4'($random(seed)));
    otss_host_inst.rd_reg(ADDR_MAX_OFF, v);
    chk_val(32'(max_intr()), v);
    for (int j = 0; j < 3; j++) begin
      v = $random(seed);
      otss_host_inst.bus_op(1'b1, 1'b0, rb_a[j], v);
      otss_host_inst.rd_reg(rb_a[j], w);
      chk_val(v & rb_m[j], w & rb_m[j]);
    end
    otss_host_inst.rd_reg(ADDR_CMD, v);
    chk_val(32'h0, v);
    otss_host_inst.rd_reg(4'h6, v);
    chk_val(32'h0, v);
    $display("test registers done");
    // mode 0 plain, mode 1 synced by panel key, mode 2 sync cleared again
    for (int m = 0; m < 3; m++) begin
      cpl = (m == 0) ? '0 : NCH'($random(seed)) | NCH'(1);
      for (int k = 0; k < NCH; k++) begin
        on_d[k] = $random(seed) & 7;
        off_d[k] = $random(seed) & 3;
      end
      otss_host_inst.setup(m == 1, cpl, on_d, off_d);
      mx = max_intr() + 1;
      if (m == 1) panel_on <= 1'b1;
      else otss_host_inst.wr_reg(ADDR_CMD, 32'h1);
      measure(1'b1);
      for (int k = 0; k < NCH; k++) begin
        n = (m == 1 && cpl[k]) ? mx + on_d[k] : intr(minfo[k]) + on_d[k];
        // counters reach zero up to one tick early: window spans one tick
        chk_win(n * TC - TC - 8, n * TC + 9, t_ev[k]);
      end
      otss_host_inst.rd_reg(ADDR_STATUS, v);
      chk_val(32'((1 << NCH) - 1), v);
      if (m == 1) panel_off <= 1'b1;
      else otss_host_inst.wr_reg(ADDR_CMD, 32'h2);
      measure(1'b0);
      for (int k = 0; k < NCH; k++) begin
        chk_win(off_d[k] * TC - TC - 8, off_d[k] * TC + 9, t_ev[k]);
      end
      otss_host_inst.rd_reg(ADDR_STATUS, v);
      chk_val(32'h0, v);
      $display("test mode %0d done", m);
    end
    otss_host_inst.wr_reg(ADDR_CMD, 32'h1);
    repeat (20) @(posedge clock);
    otss_host_inst.wr_reg(ADDR_CMD, 32'h3);
    measure(1'b1);
    for (int k = 0; k < NCH; k++) chk_win(-1, -1, t_ev[k]);
    $display("test abort done");
    complete_run();
  end
endmodule
